// file: cmb_mbc_model.sv
`timescale 1ns/100ps

// Behavioural memory bus controller on the far side of the request pins
module cmb_mbc_model (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic cyc_strobe_n,
  input  wire logic snp_strobe_n,
  input  wire logic dts_n,
  input  wire logic attr_n,
  input  wire logic cacheable,
  input  wire logic stall,
  output logic      done_n,
  output logic      burst_ack_n
);
  logic attr_q;  // Attribute captured with either strobe
  int   left;    // Acks still owed for the running cycle
  // Stalls stretch the burst, so the block must wait on done, not on a count
  always @(posedge sys_clk) begin
    done_n      <= 1'b1;
    burst_ack_n <= 1'b1;
    if (!nrst) begin
      left = 0;
    end else begin
      if (!cyc_strobe_n || !snp_strobe_n) attr_q <= attr_n;
      if (!dts_n) begin
        left = (attr_q || !cacheable) ? 1 : 4;
      end else if (left > 0 && !stall) begin
        burst_ack_n <= 1'b0;
        left--;
        if (left == 0) done_n <= 1'b0;
      end
    end
  end
endmodule // cmb_mbc_model

// file: cmb_mem_req.sv
`timescale 1ns/100ps

module cmb_mem_req #(
  parameter int unsigned AW = cmb_pkg::ADDR_W
) (
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  // Requests from the controller core
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire logic [AW-1:0]                req_addr,
  input  wire logic                         req_is_write,
  input  wire logic                         req_is_data,
  input  wire logic                         cpu_cache_attr_n,
  input  wire logic                         snoop_req,
  input  wire logic                         dp_go,
  // Pins from the processor and memory bus controller
  input  wire logic                         cpu_address_hold,
  input  wire logic                         next_addr_pipeline_enable_n,
  input  wire logic                         write_end_input_a_n,
  input  wire logic                         write_end_input_b_n,
  input  wire logic                         mem_cycle_done_n,
  // Pins toward the memory bus controller
  output logic                              mem_cycle_request_strobe_n,
  output logic                              snoop_addr_strobe_n,
  output logic                              latched_cacheability_attr_n,
  output logic                              data_or_code_ind,
  output logic                              data_path_ready_strobe_n,
  output logic                              cpu_addr_hold_track,
  output logic                              mem_addr_out_enable_n,
  output logic                              mem_addr_latch_enable,
  output logic      [AW-1:0]                mem_addr,
  output logic      [cmb_pkg::CFA_W-1:0]    configurable_addr_pins,
  output logic                              configurable_addr_oe_n,
  // Configuration and functional strap views
  output cmb_pkg::cmb_mode_t                cfg_mode,
  output cmb_pkg::cmb_ratio_t               cfg_line_ratio,
  output logic                              cfg_tag_8k,
  output logic                              cfg_two_lines_per_sector,
  output logic                              write_end_a,
  output logic                              write_end_b,
  output logic                              busy,
  // Data pins of one cache SRAM slice
  input  wire logic                         slice_parity_mode,
  input  wire logic                         slice_narrow_mode,
  input  wire logic                         slice_drive_en,
  input  wire logic [cmb_pkg::SLICE_W-1:0]  slice_wr_byte,
  input  wire logic [cmb_pkg::SLICE_W-1:0]  sram_cpu_data_slice_pins,
  output logic      [cmb_pkg::SLICE_W-1:0]  sram_cpu_data_slice_drive,
  output logic      [cmb_pkg::SLICE_W-1:0]  sram_cpu_data_slice_oe_n,
  output logic      [cmb_pkg::SLICE_W-1:0]  slice_rd_byte,
  output logic      [cmb_pkg::SLICE_LO_W-1:0] slice_bit_enables
);
  import cmb_pkg::*;

  // All state of the block except the SRAM slice
  typedef struct packed {
    cmb_state_t   st;            // Sequencer state
    logic         pipe;          // A pipelined request waits behind the current one
    logic [2:0]   pin_s1;        // Strap/functional pins, first stage
    logic [2:0]   pin_s2;        // Strap/functional pins, second stage
    logic         ah_s1;         // Address hold, first stage
    logic         ah_s2;         // Address hold, second stage
    logic         dn_s1;         // Cycle done, first stage
    logic         dn_s2;         // Cycle done, second stage
    cmb_mode_t    mode;          // Mode frozen when reset ends
    logic         run;           // Reset has ended
    logic         ads_n;         // Cycle request strobe
    logic         snp_n;         // Snoop address strobe
    logic         cache_n;       // Latched cacheability
    logic         dc;            // Data (1) or code (0)
    logic         dts_n;         // Data path ready strobe
    logic         ahtrk;         // Address hold track
    logic         aoe_n;         // Address output enable
    logic         ale;           // Address latch enable
    logic [AW-1:0] addr;         // Latched bus address
    logic [CFA_W-1:0] cfa;       // Configurable pins
    logic         cfa_oe_n;      // Configurable pins drive enable
  } cmb_state_q_t;

  cmb_state_q_t q;               // Registered state
  cmb_state_q_t d;               // Next state

  // Straps to mode; unused encodings fall back to mode 0
  function automatic cmb_mode_t strap_mode(input logic [2:0] s);
    case (s)
      3'h1:    strap_mode = CMB_MODE_1;
      3'h2:    strap_mode = CMB_MODE_2;
      3'h3:    strap_mode = CMB_MODE_3;
      3'h4:    strap_mode = CMB_MODE_4;
      default: strap_mode = CMB_MODE_0;
    endcase
  endfunction

  // Line ratio of each mode
  function automatic cmb_ratio_t mode_ratio(input cmb_mode_t m);
    case (m)
      CMB_MODE_1, CMB_MODE_2: mode_ratio = CMB_RATIO_2;
      CMB_MODE_3, CMB_MODE_4: mode_ratio = CMB_RATIO_4;
      default:                mode_ratio = CMB_RATIO_1;
    endcase
  endfunction

  // Configurable pins take address bits from a ratio-dependent base
  function automatic logic [CFA_W-1:0] cfa_map(input cmb_ratio_t r, input logic [AW-1:0] a);
    case (r)
      CMB_RATIO_2: cfa_map = a[CFA_LSB_R2 +: CFA_W];
      CMB_RATIO_4: cfa_map = a[CFA_LSB_R4 +: CFA_W];
      default:     cfa_map = a[CFA_LSB_R1 +: CFA_W];
    endcase
  endfunction

  logic na_act;                  // Next-address enable seen after reset
  logic done_act;                // Cycle done seen after reset
  logic take;                    // A request is accepted this cycle

  assign na_act   = q.run & ~q.pin_s2[STRAP_NA];
  assign done_act = q.run & ~q.dn_s2;
  // New cycle only when idle, or pipelined under next-address enable
  assign req_ready = q.run & ((q.st == CMB_IDLE) |
                     ((q.st == CMB_DONE) & na_act & ~q.pipe));
  assign take = req_valid & req_ready;

  // Next-state logic for sequencer, strobes and syncs
  always_comb begin
    d = q;
    // Pin synchronisers; only the second stage is read
    d.pin_s1 = {write_end_input_a_n, write_end_input_b_n, next_addr_pipeline_enable_n};
    d.pin_s2 = q.pin_s1;
    d.ah_s1  = cpu_address_hold;
    d.ah_s2  = q.ah_s1;
    d.dn_s1  = mem_cycle_done_n;
    d.dn_s2  = q.dn_s1;
    // Track the processor's address hold
    d.ahtrk  = q.ah_s2;
    // Strobes are single-cycle pulses by default
    d.ads_n  = STROBE_IDLE;
    d.snp_n  = STROBE_IDLE;
    d.dts_n  = STROBE_IDLE;
    d.aoe_n  = 1'b1;
    d.ale    = 1'b0;
    case (q.st)
      CMB_IDLE: begin
        if (take) begin
          d.st = CMB_ADDR;
        end else if (snoop_req & q.run) begin
          // Snoop path shares attributes but uses its own strobe
          d.snp_n   = 1'b0;
          d.cache_n = cpu_cache_attr_n;
          d.st      = CMB_DATA;
        end
      end
      CMB_ADDR: begin
        d.st = CMB_DATA;
      end
      CMB_DATA: begin
        // Data strobe waits on the data path, not on address
        if (dp_go) begin
          d.dts_n = 1'b0;                      // Read: ack may follow; write: data next clock
          d.st    = CMB_DONE;
        end
      end
      CMB_DONE: begin
        if (take) begin
          d.pipe = 1'b1;
        end
        // Done frees the cycle; a pipelined one moves on to its data phase
        if (done_act) begin
          d.st   = (q.pipe | take) ? CMB_DATA : CMB_IDLE;
          d.pipe = 1'b0;
        end
      end
      default: d.st = CMB_IDLE;
    endcase
    if (take) begin
      // Strobe with address, attributes and enables in one cycle
      d.ads_n    = 1'b0;
      d.aoe_n    = 1'b0;
      d.ale      = 1'b1;
      d.addr     = req_addr;
      d.cache_n  = cpu_cache_attr_n;           // Latched with the strobe
      d.dc       = req_is_data;                // Per-cycle data or code
      d.cfa      = cfa_map(mode_ratio(q.mode), req_addr);
      d.cfa_oe_n = 1'b0;
    end
    if (!nrst) begin
      // Straps read while reset is held; last value kept at release
      d.mode     = strap_mode(q.pin_s2);
      d.run      = 1'b0;
      d.st       = CMB_IDLE;
      d.pipe     = 1'b0;
      d.ads_n    = STROBE_IDLE;
      d.snp_n    = STROBE_IDLE;
      d.dts_n    = STROBE_IDLE;
      d.cache_n  = 1'b1;
      d.dc       = 1'b0;
      d.ahtrk    = 1'b0;
      d.aoe_n    = 1'b1;
      d.ale      = 1'b0;
      d.addr     = '0;
      d.cfa      = '0;
      d.cfa_oe_n = 1'b1;
    end else begin
      d.run = 1'b1;
    end
  end

  // One register stage for the whole block; req_is_write does not change any of it
  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  // Register-driven pin outputs
  assign mem_cycle_request_strobe_n  = q.ads_n;
  assign snoop_addr_strobe_n         = q.snp_n;
  assign latched_cacheability_attr_n = q.cache_n;
  assign data_or_code_ind            = q.dc;
  assign data_path_ready_strobe_n    = q.dts_n;
  assign cpu_addr_hold_track         = q.ahtrk;
  assign mem_addr_out_enable_n       = q.aoe_n;
  assign mem_addr_latch_enable       = q.ale;
  assign mem_addr                    = q.addr;
  assign configurable_addr_pins      = q.cfa;
  assign configurable_addr_oe_n      = q.cfa_oe_n;
  assign cfg_mode                    = q.mode;
  assign cfg_line_ratio              = mode_ratio(q.mode);
  assign cfg_tag_8k                  = (q.mode == CMB_MODE_2) | (q.mode == CMB_MODE_4);
  assign cfg_two_lines_per_sector    = (q.mode == CMB_MODE_1) | (q.mode == CMB_MODE_3) |
                                       (q.mode == CMB_MODE_4);
  // Write-end pins mean nothing until reset has ended
  assign write_end_a                 = q.run & ~q.pin_s2[STRAP_WE_A];
  assign write_end_b                 = q.run & ~q.pin_s2[STRAP_WE_B];
  assign busy                        = (q.st != CMB_IDLE);

  // Slice shares clock and reset; its pins are synchronised inside
  cmb_sram_slice slice_u (
    .sys_clk                   (sys_clk),
    .nrst                      (nrst),
    .parity_mode               (slice_parity_mode),
    .narrow_mode               (slice_narrow_mode),
    .drive_en                  (slice_drive_en),
    .wr_byte                   (slice_wr_byte),
    .sram_cpu_data_slice_pins  (sram_cpu_data_slice_pins),
    .sram_cpu_data_slice_drive (sram_cpu_data_slice_drive),
    .sram_cpu_data_slice_oe_n  (sram_cpu_data_slice_oe_n),
    .rd_byte                   (slice_rd_byte),
    .bit_enables               (slice_bit_enables)
  );

  // Write direction is carried by the core; kept for the data path hand-off
  logic unused_dir;              // Direction is informational here
  assign unused_dir = req_is_write;

endmodule // cmb_mem_req

// file: cmb_mem_req_sva.sv
`timescale 1ns/100ps

// Pin-level checks on the memory bus request block
module cmb_mem_req_sva #(
  parameter int unsigned AW = 32
) (
  input wire logic                sys_clk,
  input wire logic                nrst,
  input wire logic                req_valid,
  input wire logic                req_ready,
  input wire logic [AW-1:0]       req_addr,
  input wire logic                req_is_data,
  input wire logic                cpu_cache_attr_n,
  input wire logic                dp_go,
  input wire logic                cpu_address_hold,
  input wire logic                write_end_input_a_n,
  input wire logic                mem_cycle_request_strobe_n,
  input wire logic                snoop_addr_strobe_n,
  input wire logic                latched_cacheability_attr_n,
  input wire logic                data_or_code_ind,
  input wire logic                data_path_ready_strobe_n,
  input wire logic                cpu_addr_hold_track,
  input wire logic                mem_addr_out_enable_n,
  input wire logic                mem_addr_latch_enable,
  input wire logic [AW-1:0]       mem_addr,
  input wire logic [6:0]          configurable_addr_pins,
  input wire cmb_pkg::cmb_ratio_t cfg_line_ratio,
  input wire logic                write_end_a,
  input wire logic                write_end_input_b_n,
  input wire logic                write_end_b
);
  import cmb_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Request accepted at this edge
  wire       take = req_valid && req_ready;
  // Address bit on pin 0 follows the line ratio
  wire [2:0] lsb  = (cfg_line_ratio == CMB_RATIO_1) ? 3'h5 :
                    (cfg_line_ratio == CMB_RATIO_2) ? 3'h6 : 3'h7;
  a_req_strobe: assert property (take |=> !mem_cycle_request_strobe_n)
    else $error("accepted request gave no strobe");
  a_strobe_pulse: assert property (
    !mem_cycle_request_strobe_n |=> mem_cycle_request_strobe_n)
    else $error("request strobe longer than one cycle");
  a_addr_enables: assert property (
    !mem_cycle_request_strobe_n |-> !mem_addr_out_enable_n && mem_addr_latch_enable)
    else $error("address enables missing with strobe");
  a_addr_latch: assert property (take |=> mem_addr == $past(req_addr))
    else $error("address not latched with request");
  a_cache_attr: assert property (
    take |=> latched_cacheability_attr_n == $past(cpu_cache_attr_n))
    else $error("cacheability not latched with request");
  a_code_ind: assert property (take |=> data_or_code_ind == $past(req_is_data))
    else $error("data or code indication wrong");
  a_snoop_attr: assert property (
    !snoop_addr_strobe_n |-> latched_cacheability_attr_n == $past(cpu_cache_attr_n))
    else $error("cacheability not valid with snoop strobe");
  a_dts_cause: assert property ($fell(data_path_ready_strobe_n) |-> $past(dp_go))
    else $error("data strobe without data path ready");
  a_cfa_map: assert property (
    !mem_cycle_request_strobe_n |-> configurable_addr_pins == mem_addr[lsb +: 7])
    else $error("configurable pins do not match address");
  a_hold_track: assert property (
    $stable(cpu_address_hold) [*5] |-> cpu_addr_hold_track == cpu_address_hold)
    else $error("address hold not tracked");
  a_write_end: assert property (
    $stable(write_end_input_a_n) [*5] |-> write_end_a == !write_end_input_a_n)
    else $error("write end pin not functional after reset");
  a_write_end_b: assert property (
    $stable(write_end_input_b_n) [*5] |-> write_end_b == !write_end_input_b_n)
    else $error("second write end pin not functional after reset");
endmodule // cmb_mem_req_sva

bind cmb_mem_req cmb_mem_req_sva #(.AW(AW)) chk_u (.*);

// file: cmb_pkg.sv
package cmb_pkg;

  // Width of the address that the requester hands in
  localparam int unsigned ADDR_W      = 32;
  // Width of the configurable address pin group
  localparam int unsigned CFA_W       = 7;
  // Width of one SRAM slice data port
  localparam int unsigned SLICE_W     = 8;
  // Low nibble of a slice: parity, or the only bits in narrow builds
  localparam int unsigned SLICE_LO_W  = 4;
  // Depth of every pin synchroniser
  localparam int unsigned SYNC_DEPTH  = 2;

  // Strap positions inside the sampled strap word
  localparam int unsigned STRAP_NA    = 0;
  localparam int unsigned STRAP_WE_B  = 1;
  localparam int unsigned STRAP_WE_A  = 2;

  // Idle level of every active-low strobe
  localparam logic        STROBE_IDLE = 1'b1;
  // Reset value of the straps: all pins high
  localparam logic [2:0]  STRAP_RST   = 3'h7;

  // Address bit that lands on configurable pin 0, per line ratio
  localparam int unsigned CFA_LSB_R1  = 5;
  localparam int unsigned CFA_LSB_R2  = 6;
  localparam int unsigned CFA_LSB_R4  = 7;

  // Five configuration modes picked by the straps
  typedef enum logic [2:0] {
    CMB_MODE_0 = 3'h0,
    CMB_MODE_1 = 3'h1,
    CMB_MODE_2 = 3'h2,
    CMB_MODE_3 = 3'h3,
    CMB_MODE_4 = 3'h4
  } cmb_mode_t;

  // Line ratio of controller line to processor line
  typedef enum logic [1:0] {
    CMB_RATIO_1 = 2'h0,
    CMB_RATIO_2 = 2'h1,
    CMB_RATIO_4 = 2'h2
  } cmb_ratio_t;

  // Request sequencer, Gray along idle, address, data, done
  typedef enum logic [1:0] {
    CMB_IDLE = 2'h0,
    CMB_ADDR = 2'h1,
    CMB_DATA = 2'h3,
    CMB_DONE = 2'h2
  } cmb_state_t;

endpackage : cmb_pkg

// file: cmb_sram_slice.sv
`timescale 1ns/100ps

// One cache data SRAM slice pin group toward the processor data bus
module cmb_sram_slice (
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  input  wire logic                         parity_mode,
  input  wire logic                         narrow_mode,
  input  wire logic                         drive_en,
  input  wire logic [cmb_pkg::SLICE_W-1:0]  wr_byte,
  input  wire logic [cmb_pkg::SLICE_W-1:0]  sram_cpu_data_slice_pins,
  output logic      [cmb_pkg::SLICE_W-1:0]  sram_cpu_data_slice_drive,
  output logic      [cmb_pkg::SLICE_W-1:0]  sram_cpu_data_slice_oe_n,
  output logic      [cmb_pkg::SLICE_W-1:0]  rd_byte,
  output logic      [cmb_pkg::SLICE_LO_W-1:0] bit_enables
);
  import cmb_pkg::*;

  // All state of the slice
  typedef struct packed {
    logic [SLICE_W-1:0] s1;      // First synchroniser stage
    logic [SLICE_W-1:0] s2;      // Second synchroniser stage
    logic [SLICE_W-1:0] dout;    // Registered pin data
    logic [SLICE_W-1:0] oe_n;    // Registered enables, low drives
  } cmb_slice_t;

  cmb_slice_t q;                 // Registered state
  cmb_slice_t d;                 // Next state

  // Next state: sync the pins, then build drive data and enables
  always_comb begin
    d    = q;
    d.s1 = sram_cpu_data_slice_pins;
    d.s2 = q.s1;
    d.oe_n = {SLICE_W{1'b1}};
    d.dout = wr_byte;
    if (parity_mode) begin
      // Low nibble carries parity, high nibble is byte-enable input
      d.oe_n[SLICE_LO_W-1:0] = {SLICE_LO_W{~drive_en}};
    end else if (narrow_mode) begin
      // Upper pins stay undriven in four-pin builds
      d.oe_n[SLICE_LO_W-1:0] = {SLICE_LO_W{~drive_en}};
      d.dout[SLICE_W-1:SLICE_LO_W] = '0;
    end else begin
      // Full byte-wide data port
      d.oe_n = {SLICE_W{~drive_en}};
    end
    if (!nrst) begin
      d.oe_n = {SLICE_W{1'b1}};
      d.dout = '0;
    end
  end

  // Single register stage for the whole slice
  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  assign sram_cpu_data_slice_drive = q.dout;
  assign sram_cpu_data_slice_oe_n  = q.oe_n;
  // Narrow builds read back only the low nibble
  assign rd_byte     = narrow_mode ? {{(SLICE_W-SLICE_LO_W){1'b0}}, q.s2[SLICE_LO_W-1:0]} : q.s2;
  // Active-low byte enables arrive on the upper nibble
  assign bit_enables = parity_mode ? q.s2[SLICE_W-1:SLICE_LO_W] : '0;

endmodule // cmb_sram_slice

// file: tb.sv
`timescale 1ns/100ps

// Self-checking bench for the memory bus request block
module tb;
  import cmb_pkg::*;
  logic        sys_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_is_write = 1'b0;
  logic        req_is_data = 1'b0, cpu_cache_attr_n = 1'b1, snoop_req = 1'b0, dp_go = 1'b0;
  logic [31:0] req_addr = 32'h0, mem_addr;
  logic        cpu_address_hold = 1'b0, we_a_r = 1'b1, we_b_r = 1'b1, stall = 1'b0, na_r = 1'b1;
  logic        next_addr_pipeline_enable_n, write_end_input_a_n, write_end_input_b_n;
  logic        mem_cycle_done_n, req_ready, mem_cycle_request_strobe_n, snoop_addr_strobe_n;
  logic        latched_cacheability_attr_n, data_or_code_ind, data_path_ready_strobe_n;
  logic        cpu_addr_hold_track, mem_addr_out_enable_n, mem_addr_latch_enable;
  logic [6:0]  configurable_addr_pins;
  logic        configurable_addr_oe_n, cfg_tag_8k, cfg_two_lines_per_sector;
  logic        write_end_a, write_end_b, busy;
  cmb_mode_t   cfg_mode;
  cmb_ratio_t  cfg_line_ratio;
  logic        slice_parity_mode = 1'b0, slice_narrow_mode = 1'b0, slice_drive_en = 1'b0;
  logic [7:0]  slice_wr_byte = 8'h00, sram_cpu_data_slice_pins = 8'h00;
  logic [7:0]  sram_cpu_data_slice_drive, sram_cpu_data_slice_oe_n, slice_rd_byte;
  logic [3:0]  slice_bit_enables;
  logic [2:0]  strap = 3'h0, m;
  int          seed = 98, seed_bg = 98, n_mismatch = 0, n_tests = 0;

  // Straps sit on the shared pins only while reset is held
  assign write_end_input_a_n         = nrst ? we_a_r : strap[2];
  assign write_end_input_b_n         = nrst ? we_b_r : strap[1];
  assign next_addr_pipeline_enable_n = nrst ? na_r : strap[0];

  cmb_mem_req dut_u (.*);
  cmb_mbc_model mbc_u (.sys_clk(sys_clk), .nrst(nrst), .cyc_strobe_n(mem_cycle_request_strobe_n),
    .snp_strobe_n(snoop_addr_strobe_n), .dts_n(data_path_ready_strobe_n),
    .attr_n(latched_cacheability_attr_n), .cacheable(strap[1]), .stall(stall),
    .done_n(mem_cycle_done_n), .burst_ack_n());

  always #5 sys_clk = ~sys_clk;

  // Slow pins wander; own seed keeps this apart from the main sequence
  always @(posedge sys_clk) begin
    #1;
    stall = $random(seed_bg);
    if (($random(seed_bg) & 7) == 0) cpu_address_hold = ~cpu_address_hold;
    if (($random(seed_bg) & 7) == 0) we_a_r = ~we_a_r;
    if (($random(seed_bg) & 7) == 0) we_b_r = ~we_b_r;
  end

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Straps above four fall back to mode zero
  function automatic logic [2:0] exp_mode(input logic [2:0] s);
    return (s > 3'h4) ? 3'h0 : s;
  endfunction

  function automatic int lsb_of(input logic [2:0] md);
    return (md == 3'h0) ? 5 : (md < 3'h3) ? 6 : 7;
  endfunction

  // One request or snoop, its data strobe and the wait for idle
  // Keep leaves the cycle in its done phase; piped expects a take behind it
  task automatic run_cycle(input logic snp, input logic corner, input logic keep,
                           input logic piped);
    logic [31:0] a;
    logic        d;
    logic        c;
    int          k;
    a = corner ? {32{strap[0]}} : $random(seed);
    d = $random(seed);
    c = $random(seed);
    {req_addr, req_is_data, cpu_cache_attr_n, req_is_write} = {a, d, c, 1'($random(seed))};
    if (snp) snoop_req = 1'b1;
    else req_valid = 1'b1;
    k = 0;
    while (!snp && req_ready !== 1'b1 && k < 50) begin
      @(posedge sys_clk);
      #1 k++;
    end
    if (piped) check("pipelined", 1, busy);
    @(posedge sys_clk);
    #1 {req_valid, snoop_req} = 2'b00;
    if (snp) begin
      check("snoop_strobe", 0, snoop_addr_strobe_n);
    end else begin
      check("req_strobe", 0, mem_cycle_request_strobe_n);
      check("refused", 0, req_ready);
      check("addr", a, mem_addr);
      check("data_or_code", d, data_or_code_ind);
      check("cfa", (a >> lsb_of(m)) & 32'h0000007F, configurable_addr_pins);
      check("cfa_oe", 0, configurable_addr_oe_n);
    end
    check("cache_attr", c, latched_cacheability_attr_n);
    repeat (1 + ($random(seed) & 3)) @(posedge sys_clk);
    #1 dp_go = 1'b1;
    // Held until taken: a pipelined cycle waits for the previous done
    k = 0;
    while (data_path_ready_strobe_n !== 1'b0 && k < 60) begin
      @(posedge sys_clk);
      #1 k++;
    end
    dp_go = 1'b0;
    check("data_strobe", 0, data_path_ready_strobe_n);
    k = 0;
    while (!keep && busy !== 1'b0 && k < 60) begin
      @(posedge sys_clk);
      #1 k++;
    end
    check("idle", keep, busy);
  endtask

  // One slice setup: drive a byte, read the pins back, then release them
  task automatic slice_case(input logic par, input logic nar);
    logic [7:0] w;
    logic [7:0] p;
    w = $random(seed);
    p = $random(seed);
    {slice_parity_mode, slice_narrow_mode, slice_drive_en} = {par, nar, 1'b1};
    {slice_wr_byte, sram_cpu_data_slice_pins} = {w, p};
    repeat (2) @(posedge sys_clk);
    #1 check("slice_oe", (par || nar) ? 8'hF0 : 8'h00, sram_cpu_data_slice_oe_n);
    check("slice_drive", (nar && !par) ? {4'h0, w[3:0]} : w, sram_cpu_data_slice_drive);
    check("slice_read", nar ? {4'h0, p[3:0]} : p, slice_rd_byte);
    check("slice_enables", par ? p[7:4] : 4'h0, slice_bit_enables);
    slice_drive_en = 1'b0;
    @(posedge sys_clk);
    #1 check("slice_release", 8'hFF, sram_cpu_data_slice_oe_n);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Every strap value, then traffic in the mode it picks
  initial begin
    for (int s = 0; s < 8; s++) begin
      @(posedge sys_clk);
      #1 nrst = 1'b0;
      strap = s[2:0];
      repeat (6) @(posedge sys_clk);
      #1 nrst = 1'b1;
      m = exp_mode(strap);
      @(posedge sys_clk);
      #1 check("mode", m, cfg_mode);
      check("ratio", (m == 3'h0) ? 0 : (m < 3'h3) ? 1 : 2, cfg_line_ratio);
      check("tag_8k", m == 3'h2 || m == 3'h4, cfg_tag_8k);
      check("lines", m != 3'h0 && m != 3'h2, cfg_two_lines_per_sector);
      for (int i = 0; i < 4; i++) run_cycle(i == 3, i == 0, 1'b0, 1'b0);
      // Second request rides behind the first under next-address enable
      na_r = 1'b0;
      run_cycle(1'b0, 1'b0, 1'b1, 1'b0);
      run_cycle(1'b0, 1'b0, 1'b0, 1'b1);
      na_r = 1'b1;
      slice_case(s[0], s[1]);
    end
    report_and_stop();
  end

  // Whole run needs about a thousand cycles; ten times that means a hang
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
endmodule // tb
